// file: verilog/pqs_regs.vh
// Constants of the program queue sequencer
`ifndef PQS_REGS_VH
`define PQS_REGS_VH
// -------------------------------------------------------------
// Host command codes
// -------------------------------------------------------------
`define PQS_H_FILL 3'h0
`define PQS_H_RUN 3'h1
`define PQS_H_STORE 3'h2
`define PQS_H_READ 3'h3
`define PQS_H_LINE 3'h4
// -------------------------------------------------------------
// Queue line layout and line ops
// -------------------------------------------------------------
`define PQS_OP_MSB 15
`define PQS_OP_LSB 12
`define PQS_A_MSB 11
`define PQS_A_LSB 6
`define PQS_T_MSB 5
`define PQS_T_LSB 0
`define PQS_OP_STOP 4'h1
`define PQS_OP_LOOP 4'h2
`define PQS_OP_FILLRUN 4'h3
`define PQS_OP_BRANCH 4'h4
// -------------------------------------------------------------
// Sizes and limits
// -------------------------------------------------------------
`define PQS_QUEUE 4'h0
`define PQS_SLOT_MAX 4'hC
`define PQS_SLOT_LAST 12
`define PQS_MEM_LAST 831
`define PQS_DREG_LAST 31
`define PQS_LINE_MAX 6'h3E
`define PQS_ZERO6 6'h00
`define PQS_ONE6 6'h01
`define PQS_ONE7 7'h01
`define PQS_DREG_ONE 16'h0001
`define PQS_DREG_RST 16'h0000
// -------------------------------------------------------------
// Reply kinds, refusal codes, readout phases
// -------------------------------------------------------------
`define PQS_R_ACK 3'h0
`define PQS_R_NAK 3'h1
`define PQS_R_COUNT 3'h2
`define PQS_R_LINE 3'h3
`define PQS_R_CODE 3'h4
`define PQS_C_EMPTY 16'h0000
`define PQS_C_RUNNING 16'hFFFF
`define PQS_C_BUSY 16'hFFFE
`define PQS_C_LOCKED 16'hFFFD
`define PQS_PH_ACK 7'h00
`define PQS_PH_HEAD 7'h01
`define PQS_PH_BODY 7'h02
`endif

// file: verilog/pqs_sequencer.v
// Program queue sequencer: queue, segment slots, run engine, readout
`timescale 1ns/1ps
`include "pqs_regs.vh"
module pqs_sequencer (
   input wire clk_i,
   input wire rstn_i,
   input wire cmd_valid_i,
   output wire cmd_ready_o,
   input wire [2:0] cmd_op_i,
   input wire [3:0] cmd_arg_i,
   input wire [15:0] cmd_word_i,
   output wire rep_valid_o,
   input wire rep_ready_i,
   output wire [2:0] rep_kind_o,
   output wire [15:0] rep_value_o,
   output wire exec_valid_o,
   input wire exec_ready_i,
   output wire [15:0] exec_word_o,
   input wire dreg_we_i,
   input wire [4:0] dreg_idx_i,
   input wire [15:0] dreg_val_i,
   input wire [7:0] cond_i,
   input wire locked_i,
   output wire running_o,
   output wire filling_o
);
   localparam S_IDLE = 3'h0;
   localparam S_COPY = 3'h1;
   localparam S_FETCH = 3'h2;
   localparam S_EMIT = 3'h3;
   localparam S_READ = 3'h4;
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   reg [15:0] mem [0:`PQS_MEM_LAST];
   reg [5:0] len_ff [0:`PQS_SLOT_LAST];
   reg [15:0] dreg_ff [0:`PQS_DREG_LAST];
   reg [2:0] state_ff, nxt_state;
   reg run_ff, nxt_run;
   reg fill_ff, nxt_fill;
   reg [5:0] pc_ff, nxt_pc;
   reg [6:0] idx_ff, nxt_idx;
   reg [3:0] src_ff, nxt_src;
   reg [3:0] dst_ff, nxt_dst;
   reg [5:0] cnt_ff, nxt_cnt;
   reg go_ff, nxt_go;
   reg [3:0] rslot_ff, nxt_rslot;
   reg rref_ff, nxt_rref;
   reg [15:0] rval_ff, nxt_rval;
   reg busy_ff, nxt_busy;
   reg [15:0] xw_ff, nxt_xw;
   reg xv_ff, nxt_xv;
   reg mem_we, len_we, dec_we, push;
   reg [9:0] mem_wa;
   reg [15:0] mem_wd;
   reg [3:0] len_wa;
   reg [5:0] len_wd;
   reg [4:0] dec_i;
   reg [2:0] p_kind;
   reg [15:0] p_val;
   reg cp_go, cp_run, rd_go;
   reg [3:0] cp_src, cp_dst;
   reg [18:0] f0_ff, f1_ff;
   reg [1:0] fcnt_ff;
   integer i;
   // -------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------
   wire f_in_rdy = (fcnt_ff != 2'h2);
   wire [5:0] len0 = len_ff[`PQS_QUEUE];
   wire [15:0] cur_w = mem[{`PQS_QUEUE, pc_ff}];
   wire [3:0] w_op = cur_w[`PQS_OP_MSB:`PQS_OP_LSB];
   wire [5:0] w_a = cur_w[`PQS_A_MSB:`PQS_A_LSB];
   wire [5:0] w_t = cur_w[`PQS_T_MSB:`PQS_T_LSB];
   wire [6:0] line_n = {1'b0, pc_ff} + `PQS_ONE7;
   wire t_in = (w_t != `PQS_ZERO6) && (w_t <= len0);
   wire [15:0] cnt_v = dreg_ff[w_a[4:0]];
   wire loop_go = t_in && ({1'b0, w_t} <= line_n) && (cnt_v > `PQS_DREG_ONE);
   wire br_go = t_in && ({1'b0, w_t} != line_n) && cond_i[w_a[2:0]];
   wire w_slot = (w_a != `PQS_ZERO6) && (w_a <= {2'b00, `PQS_SLOT_MAX});
   wire [3:0] hw_op = cmd_word_i[`PQS_OP_MSB:`PQS_OP_LSB];
   wire [5:0] hw_a = cmd_word_i[`PQS_A_MSB:`PQS_A_LSB];
   wire hw_slot = (hw_a != `PQS_ZERO6) && (hw_a <= {2'b00, `PQS_SLOT_MAX});
   wire h_slot = (cmd_arg_i != `PQS_QUEUE) && (cmd_arg_i <= `PQS_SLOT_MAX);
   wire [5:0] rlen = len_ff[rslot_ff];
   wire [6:0] rlen_p1 = {1'b0, rlen} + `PQS_ONE7;
   wire [6:0] rd_m = idx_ff - `PQS_PH_BODY;
   wire [15:0] rd_w = mem[{rslot_ff, rd_m[5:0]}];
   wire [15:0] cp_w = mem[{src_ff, idx_ff[5:0]}];
   wire rd_done = rref_ff ? (idx_ff == `PQS_PH_HEAD) : (idx_ff == rlen_p1);
   // Host lines stall while a program runs; readout may overlap readout
   assign cmd_ready_o = f_in_rdy && ((state_ff == S_IDLE) ||
      ((state_ff == S_FETCH) && (cmd_op_i != `PQS_H_LINE)) ||
      ((state_ff == S_READ) && (cmd_op_i == `PQS_H_READ) && !busy_ff));
   wire cmd_fire = cmd_valid_i && cmd_ready_o;
   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always @* begin
      nxt_state = state_ff;
      nxt_run = run_ff;
      nxt_fill = fill_ff;
      nxt_pc = pc_ff;
      nxt_idx = idx_ff;
      nxt_src = src_ff;
      nxt_dst = dst_ff;
      nxt_cnt = cnt_ff;
      nxt_go = go_ff;
      nxt_rslot = rslot_ff;
      nxt_rref = rref_ff;
      nxt_rval = rval_ff;
      nxt_busy = busy_ff;
      nxt_xw = xw_ff;
      nxt_xv = xv_ff;
      mem_we = 1'b0;
      mem_wa = {`PQS_QUEUE, len0};
      mem_wd = cmd_word_i;
      len_we = 1'b0;
      len_wa = `PQS_QUEUE;
      len_wd = `PQS_ZERO6;
      dec_we = 1'b0;
      dec_i = w_a[4:0];
      push = 1'b0;
      p_kind = `PQS_R_ACK;
      p_val = `PQS_C_EMPTY;
      cp_go = 1'b0;
      cp_run = 1'b0;
      cp_src = cmd_arg_i;
      cp_dst = `PQS_QUEUE;
      rd_go = 1'b0;
      case (state_ff)
         S_IDLE, S_FETCH: begin
            if (cmd_fire) begin
               push = 1'b1;
               case (cmd_op_i)
                  `PQS_H_FILL: begin
                     if (cmd_arg_i == `PQS_QUEUE) begin
                        nxt_fill = 1'b1;
                        nxt_run = 1'b0;
                        nxt_state = S_IDLE;
                        len_we = 1'b1;
                     end else if (h_slot) begin
                        nxt_fill = 1'b0;
                        nxt_run = 1'b0;
                        cp_go = 1'b1;
                     end else begin
                        p_kind = `PQS_R_NAK;
                     end
                  end
                  `PQS_H_RUN: begin
                     nxt_fill = 1'b0;
                     nxt_run = 1'b1;
                     nxt_pc = `PQS_ZERO6;
                     nxt_state = S_FETCH;
                  end
                  `PQS_H_STORE: begin
                     nxt_fill = 1'b0;
                     if (h_slot) begin
                        cp_go = 1'b1;
                        cp_src = `PQS_QUEUE;
                        cp_dst = cmd_arg_i;
                     end else begin
                        p_kind = `PQS_R_NAK;
                     end
                  end
                  `PQS_H_READ: begin
                     if (cmd_arg_i <= `PQS_SLOT_MAX) begin
                        push = 1'b0;
                        rd_go = 1'b1;
                     end else begin
                        p_kind = `PQS_R_NAK;
                     end
                  end
                  `PQS_H_LINE: begin
                     if (fill_ff) begin
                        if (len0 < `PQS_LINE_MAX) begin
                           mem_we = 1'b1;
                           len_we = 1'b1;
                           len_wd = len0 + `PQS_ONE6;
                        end else begin
                           p_kind = `PQS_R_NAK;
                        end
                     end else begin
                        // Host line outside a fill runs on its own; loop and branch lines are refused
                        case (hw_op)
                           `PQS_OP_STOP: nxt_run = 1'b0;
                           `PQS_OP_FILLRUN: begin
                              if (hw_slot) begin
                                 cp_go = 1'b1;
                                 cp_run = 1'b1;
                                 cp_src = hw_a[3:0];
                              end else begin
                                 p_kind = `PQS_R_NAK;
                              end
                           end
                           `PQS_OP_LOOP, `PQS_OP_BRANCH: p_kind = `PQS_R_NAK;
                           default: begin
                              nxt_xw = cmd_word_i;
                              nxt_xv = 1'b1;
                              nxt_state = S_EMIT;
                           end
                        endcase
                     end
                  end
                  default: p_kind = `PQS_R_NAK;
               endcase
            end else if (state_ff == S_FETCH) begin
               if (pc_ff >= len0) begin
                  nxt_run = 1'b0;
                  nxt_state = S_IDLE;
               end else begin
                  nxt_pc = line_n[5:0];
                  case (w_op)
                     `PQS_OP_STOP: begin
                        nxt_pc = pc_ff;
                        nxt_run = 1'b0;
                        nxt_state = S_IDLE;
                     end
                     `PQS_OP_LOOP: begin
                        if (loop_go) begin
                           nxt_pc = w_t - `PQS_ONE6;
                           dec_we = 1'b1;
                        end
                     end
                     `PQS_OP_BRANCH: begin
                        if (br_go) begin
                           nxt_pc = w_t - `PQS_ONE6;
                        end
                     end
                     `PQS_OP_FILLRUN: begin
                        if (w_slot) begin
                           cp_go = 1'b1;
                           cp_run = 1'b1;
                           cp_src = w_a[3:0];
                        end
                     end
                     default: begin
                        nxt_xw = cur_w;
                        nxt_xv = 1'b1;
                        nxt_state = S_EMIT;
                     end
                  endcase
               end
            end
         end
         S_COPY: begin
            if (idx_ff < {1'b0, cnt_ff}) begin
               mem_we = 1'b1;
               mem_wa = {dst_ff, idx_ff[5:0]};
               mem_wd = cp_w;
               nxt_idx = idx_ff + `PQS_ONE7;
            end else if (go_ff) begin
               nxt_run = 1'b1;
               nxt_pc = `PQS_ZERO6;
               nxt_state = S_FETCH;
            end else begin
               nxt_state = run_ff ? S_FETCH : S_IDLE;
            end
         end
         S_EMIT: begin
            if (exec_ready_i) begin
               nxt_xv = 1'b0;
               nxt_state = run_ff ? S_FETCH : S_IDLE;
            end
         end
         S_READ: begin
            if (cmd_fire) begin
               nxt_busy = 1'b1;
            end
            if (f_in_rdy) begin
               push = 1'b1;
               if (idx_ff == `PQS_PH_ACK) begin
                  p_kind = `PQS_R_ACK;
               end else if (idx_ff == `PQS_PH_HEAD) begin
                  p_kind = rref_ff ? `PQS_R_CODE : `PQS_R_COUNT;
                  p_val = rref_ff ? rval_ff : {9'h000, rlen_p1};
               end else begin
                  p_kind = `PQS_R_LINE;
                  p_val = rd_w;
               end
               if (!rd_done) begin
                  nxt_idx = idx_ff + `PQS_ONE7;
               end else if (busy_ff || cmd_fire) begin
                  nxt_busy = 1'b0;
                  nxt_idx = `PQS_PH_ACK;
                  nxt_rref = 1'b1;
                  nxt_rval = `PQS_C_BUSY;
               end else begin
                  nxt_state = run_ff ? S_FETCH : S_IDLE;
               end
            end
         end
         default: nxt_state = S_IDLE;
      endcase
      if (cp_go) begin
         nxt_state = S_COPY;
         nxt_src = cp_src;
         nxt_dst = cp_dst;
         nxt_cnt = len_ff[cp_src];
         nxt_idx = `PQS_PH_ACK;
         nxt_go = cp_run;
         len_we = 1'b1;
         len_wa = cp_dst;
         len_wd = len_ff[cp_src];
      end
      if (rd_go) begin
         nxt_state = S_READ;
         nxt_rslot = cmd_arg_i;
         nxt_idx = `PQS_PH_ACK;
         nxt_rref = run_ff || ((cmd_arg_i != `PQS_QUEUE) && locked_i) ||
            (len_ff[cmd_arg_i] == `PQS_ZERO6);
         nxt_rval = run_ff ? `PQS_C_RUNNING :
            (((cmd_arg_i != `PQS_QUEUE) && locked_i) ? `PQS_C_LOCKED : `PQS_C_EMPTY);
      end
   end
   // -------------------------------------------------------------
   // Registers and storage
   // -------------------------------------------------------------
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         state_ff <= S_IDLE;
         run_ff <= 1'b0;
         fill_ff <= 1'b0;
         pc_ff <= `PQS_ZERO6;
         idx_ff <= `PQS_PH_ACK;
         src_ff <= `PQS_QUEUE;
         dst_ff <= `PQS_QUEUE;
         cnt_ff <= `PQS_ZERO6;
         go_ff <= 1'b0;
         rslot_ff <= `PQS_QUEUE;
         rref_ff <= 1'b0;
         rval_ff <= `PQS_C_EMPTY;
         busy_ff <= 1'b0;
         xw_ff <= `PQS_DREG_RST;
         xv_ff <= 1'b0;
         for (i = 0; i <= `PQS_SLOT_LAST; i = i + 1) begin
            len_ff[i] <= `PQS_ZERO6;
         end
         for (i = 0; i <= `PQS_DREG_LAST; i = i + 1) begin
            dreg_ff[i] <= `PQS_DREG_RST;
         end
      end else begin
         state_ff <= nxt_state;
         run_ff <= nxt_run;
         fill_ff <= nxt_fill;
         pc_ff <= nxt_pc;
         idx_ff <= nxt_idx;
         src_ff <= nxt_src;
         dst_ff <= nxt_dst;
         cnt_ff <= nxt_cnt;
         go_ff <= nxt_go;
         rslot_ff <= nxt_rslot;
         rref_ff <= nxt_rref;
         rval_ff <= nxt_rval;
         busy_ff <= nxt_busy;
         xw_ff <= nxt_xw;
         xv_ff <= nxt_xv;
         if (len_we) begin
            len_ff[len_wa] <= len_wd;
         end
         // Host preload wins over a decrement of the same register
         for (i = 0; i <= `PQS_DREG_LAST; i = i + 1) begin
            if (dreg_we_i && (dreg_idx_i == i[4:0])) begin
               dreg_ff[i] <= dreg_val_i;
            end else if (dec_we && (dec_i == i[4:0])) begin
               dreg_ff[i] <= dreg_ff[i] - `PQS_DREG_ONE;
            end
         end
      end
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end
   // -------------------------------------------------------------
   // Two-entry reply buffer
   // -------------------------------------------------------------
   wire pop = (fcnt_ff != 2'h0) && rep_ready_i;
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         fcnt_ff <= 2'h0;
         f0_ff <= 19'h0_0000;
         f1_ff <= 19'h0_0000;
      end else begin
         if (push && !pop) begin
            fcnt_ff <= fcnt_ff + 2'h1;
            if (fcnt_ff == 2'h0) begin
               f0_ff <= {p_kind, p_val};
            end else begin
               f1_ff <= {p_kind, p_val};
            end
         end else if (pop && !push) begin
            fcnt_ff <= fcnt_ff - 2'h1;
            f0_ff <= f1_ff;
         end else if (pop && push) begin
            if (fcnt_ff == 2'h1) begin
               f0_ff <= {p_kind, p_val};
            end else begin
               f0_ff <= f1_ff;
               f1_ff <= {p_kind, p_val};
            end
         end
      end
   end
   assign rep_valid_o = (fcnt_ff != 2'h0);
   assign rep_kind_o = f0_ff[18:16];
   assign rep_value_o = f0_ff[15:0];
   assign exec_valid_o = xv_ff;
   assign exec_word_o = xw_ff;
   assign running_o = run_ff;
   assign filling_o = fill_ff;
endmodule // pqs_sequencer

// file: verification/pqs_sequencer_assertions.sv
// Port-level checker of the program queue sequencer
`timescale 1ns/1ps
`include "pqs_regs.vh"
module pqs_sequencer_assertions (
   input wire clk_i,
   input wire rstn_i,
   input wire cmd_valid_i,
   input wire cmd_ready_o,
   input wire [2:0] cmd_op_i,
   input wire [3:0] cmd_arg_i,
   input wire rep_valid_o,
   input wire rep_ready_i,
   input wire [2:0] rep_kind_o,
   input wire [15:0] rep_value_o,
   input wire exec_valid_o,
   input wire exec_ready_i,
   input wire [15:0] exec_word_o,
   input wire running_o,
   input wire filling_o
);
   wire take = cmd_valid_i && cmd_ready_o;
   wire ends_fill = (cmd_op_i == `PQS_H_RUN) ||
      (cmd_op_i == `PQS_H_STORE && cmd_arg_i != 4'h0 && cmd_arg_i <= `PQS_SLOT_MAX);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   a_reset_quiet: assert property ($rose(rstn_i) |-> !rep_valid_o && !exec_valid_o
      && !running_o && !filling_o && cmd_ready_o) else $error("outputs busy after reset");
   a_rep_hold: assert property (rep_valid_o && !rep_ready_i |=> rep_valid_o
      && $stable(rep_kind_o) && $stable(rep_value_o)) else $error("stalled reply changed");
   a_exec_hold: assert property (exec_valid_o && !exec_ready_i |=> exec_valid_o
      && $stable(exec_word_o)) else $error("stalled command word changed");
   a_nak_opcode: assert property (take && cmd_op_i >= 3'h5 && !rep_valid_o |=>
      rep_valid_o && rep_kind_o == `PQS_R_NAK) else $error("unknown op not refused");
   a_fill_start: assert property (take && cmd_op_i == `PQS_H_FILL && cmd_arg_i == 4'h0
      |=> filling_o) else $error("host fill did not start");
   a_fill_end: assert property (filling_o && take && ends_fill |=> !filling_o)
      else $error("host fill did not end");
   a_line_refused: assert property (running_o && cmd_op_i == `PQS_H_LINE |-> !cmd_ready_o)
      else $error("line taken while running");
   a_count_range: assert property (rep_valid_o && rep_kind_o == `PQS_R_COUNT |->
      rep_value_o >= 16'h0001 && rep_value_o <= 16'h003f) else $error("count out of range");
   a_code_values: assert property (rep_valid_o && rep_kind_o == `PQS_R_CODE |->
      rep_value_o inside {`PQS_C_EMPTY, `PQS_C_RUNNING, `PQS_C_BUSY, `PQS_C_LOCKED})
      else $error("unknown refusal code");
endmodule // pqs_sequencer_assertions

// file: verification/pqs_host_model.sv
// Host-side consumer of replies and command words, with stall modes
`timescale 1ns/1ps
module pqs_host_model (
   input wire clk_i,
   input wire [1:0] mode_i,
   output reg rep_ready_o = 1'b1,
   output reg exec_ready_o = 1'b1
);
   // Mode 0 prompt, 1 slow on both, 2 executor holds off
   reg [1:0] cnt_ff = 2'h0;
   always @(posedge clk_i) begin
      cnt_ff <= cnt_ff + 2'h1;
      rep_ready_o <= (mode_i != 2'h1) || (cnt_ff == 2'h0);
      exec_ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && cnt_ff == 2'h2);
   end
endmodule // pqs_host_model

// file: verification/tb_pqs_sequencer.sv
// Self-checking bench of the program queue sequencer
`timescale 1ns/1ps
`include "pqs_regs.vh"
module tb_pqs_sequencer;
   localparam [15:0] wd1 = 16'h0a01;
   localparam [15:0] wd2 = 16'h0a02;
   localparam [15:0] wd3 = 16'h0a03;
   localparam [15:0] wd4 = 16'h0a04;
   reg clk_i = 1'b0;
   reg rstn_i = 1'b0;
   reg cmd_valid = 1'b0;
   reg [2:0] cmd_op = 3'h0;
   reg [3:0] cmd_arg = 4'h0;
   reg [15:0] cmd_word = 16'h0000;
   reg dreg_we = 1'b0;
   reg [4:0] dreg_idx = 5'h00;
   reg [15:0] dreg_val = 16'h0000;
   reg [7:0] cond = 8'h00;
   reg locked = 1'b0;
   reg [1:0] mode = 2'h0;
   wire cmd_ready, rep_valid, rep_ready, exec_valid, exec_ready, running, filling;
   wire [2:0] rep_kind;
   wire [15:0] rep_value, exec_word;
   integer n_fail = 0;
   integer cmp_count = 0;
   logic [18:0] rq[$];
   logic [15:0] eq[$];
   always #2.5 clk_i = ~clk_i;
   pqs_sequencer uut (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid),
      .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op), .cmd_arg_i(cmd_arg), .cmd_word_i(cmd_word),
      .rep_valid_o(rep_valid), .rep_ready_i(rep_ready), .rep_kind_o(rep_kind),
      .rep_value_o(rep_value), .exec_valid_o(exec_valid), .exec_ready_i(exec_ready),
      .exec_word_o(exec_word), .dreg_we_i(dreg_we), .dreg_idx_i(dreg_idx),
      .dreg_val_i(dreg_val), .cond_i(cond), .locked_i(locked), .running_o(running),
      .filling_o(filling));
   pqs_host_model host (.clk_i(clk_i), .mode_i(mode), .rep_ready_o(rep_ready),
      .exec_ready_o(exec_ready));
   // -------------------------------------------------------------
   // Collect replies and command words as they are handed over
   // -------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rep_valid === 1'b1 && rep_ready === 1'b1)
         rq.push_back({rep_kind, rep_value});
      if (exec_valid === 1'b1 && exec_ready === 1'b1)
         eq.push_back(exec_word);
   end
   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task complete_run;
      begin
         if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input string what, input [18:0] exp, input [18:0] got);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            n_fail = n_fail + 1;
         end
      end
   endtask
   task hang(input string what);
      begin
         $display("[FAIL] %s expected done seen timeout", what);
         n_fail = n_fail + 1;
         complete_run;
      end
   endtask
   task send(input [2:0] op, input [3:0] arg, input [15:0] w);
      integer k;
      reg tk;
      begin
         tk = 1'b0;
         @(posedge clk_i);
         cmd_valid <= 1'b1;
         cmd_op <= op;
         cmd_arg <= arg;
         cmd_word <= w;
         for (k = 0; k < 400 && !tk; k = k + 1) begin
            @(negedge clk_i);
            tk = (cmd_ready === 1'b1);
            @(posedge clk_i);
         end
         cmd_valid <= 1'b0;
         if (!tk)
            hang("cmd_ready");
      end
   endtask
   task exp_rep(input [2:0] kind, input [15:0] val);
      integer k;
      reg [18:0] v;
      begin
         for (k = 0; k < 400 && rq.size() == 0; k = k + 1)
            @(posedge clk_i);
         if (rq.size() == 0)
            hang("reply");
         v = rq.pop_front();
         chk("reply", {kind, val}, v);
      end
   endtask
   task exp_exec(input [15:0] w);
      integer k;
      begin
         for (k = 0; k < 400 && eq.size() == 0; k = k + 1)
            @(posedge clk_i);
         if (eq.size() == 0)
            hang("exec_word");
         chk("exec_word", {3'h0, w}, {3'h0, eq.pop_front()});
      end
   endtask
   task cmd(input [2:0] op, input [3:0] arg, input [15:0] w, input [2:0] kind);
      begin
         send(op, arg, w);
         exp_rep(kind, 16'h0000);
      end
   endtask
   task load(input integer n, input [15:0] a, input [15:0] b, input [15:0] c);
      integer i;
      begin
         cmd(`PQS_H_FILL, 4'h0, 16'h0000, `PQS_R_ACK);
         for (i = 0; i < n; i = i + 1)
            cmd(`PQS_H_LINE, 4'h0, i == 0 ? a : (i == 1 ? b : c), `PQS_R_ACK);
      end
   endtask
   task run_q;
      cmd(`PQS_H_RUN, 4'h0, 16'h0000, `PQS_R_ACK);
   endtask
   task readout(input [3:0] s, input [15:0] n, input [15:0] a, input [15:0] b);
      begin
         cmd(`PQS_H_READ, s, 16'h0000, `PQS_R_ACK);
         exp_rep(`PQS_R_COUNT, n + 16'h0001);
         exp_rep(`PQS_R_LINE, a);
         if (n > 16'h0001)
            exp_rep(`PQS_R_LINE, b);
      end
   endtask
   // Lets a finished run settle, then no further word may appear
   task wait_idle;
      integer k;
      begin
         for (k = 0; k < 400 && running !== 1'b0; k = k + 1)
            @(posedge clk_i);
         repeat (8) @(posedge clk_i);
         chk("running", 19'h0, {18'h0, running});
         chk("extra words", 19'h0, eq.size());
      end
   endtask
   task set_reg(input [4:0] i, input [15:0] v);
      begin
         @(posedge clk_i);
         dreg_we <= 1'b1;
         dreg_idx <= i;
         dreg_val <= v;
         @(posedge clk_i);
         dreg_we <= 1'b0;
      end
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task t_fill_store;
      begin
         load(2, wd1, wd2, 16'h0000);
         @(negedge clk_i);
         chk("filling", 19'h1, {18'h0, filling});
         cmd(`PQS_H_STORE, 4'h1, 16'h0000, `PQS_R_ACK);
         @(negedge clk_i);
         chk("filling", 19'h0, {18'h0, filling});
         @(posedge clk_i);
         mode <= 2'h1;
         readout(4'h1, 16'h0002, wd1, wd2);
         readout(4'h0, 16'h0002, wd1, wd2);
         mode <= 2'h0;
      end
   endtask
   task t_refusals;
      integer op;
      begin
         cmd(`PQS_H_READ, 4'h7, 16'h0000, `PQS_R_ACK);
         exp_rep(`PQS_R_CODE, `PQS_C_EMPTY);
         locked <= 1'b1;
         cmd(`PQS_H_READ, 4'h1, 16'h0000, `PQS_R_ACK);
         exp_rep(`PQS_R_CODE, `PQS_C_LOCKED);
         locked <= 1'b0;
         for (op = 5; op < 8; op = op + 1)
            cmd(op[2:0], 4'h0, 16'h0000, `PQS_R_NAK);
         cmd(`PQS_H_FILL, 4'hd, 16'h0000, `PQS_R_NAK);
         mode <= 2'h2;
         load(1, wd3, 16'h0000, 16'h0000);
         run_q;
         @(posedge clk_i);
         cmd_valid <= 1'b1;
         cmd_op <= `PQS_H_LINE;
         @(negedge clk_i);
         chk("cmd_ready", 19'h0, {18'h0, cmd_ready});
         @(posedge clk_i);
         cmd_valid <= 1'b0;
         // Word stalls until the slow executor takes it; readout then lands mid-run
         mode <= 2'h1;
         cmd(`PQS_H_READ, 4'h1, 16'h0000, `PQS_R_ACK);
         exp_rep(`PQS_R_CODE, `PQS_C_RUNNING);
         exp_exec(wd3);
         wait_idle;
         readout(4'h0, 16'h0001, wd3, 16'h0000);
         cmd(`PQS_H_FILL, 4'h1, 16'h0000, `PQS_R_ACK);
         readout(4'h0, 16'h0002, wd1, wd2);
         mode <= 2'h0;
      end
   endtask
   task t_loop;
      begin
         set_reg(5'h03, 16'h0003);
         load(2, wd1, 16'h20c1, 16'h0000);
         run_q;
         repeat (3) exp_exec(wd1);
         wait_idle;
         run_q;
         exp_exec(wd1);
         wait_idle;
         set_reg(5'h03, 16'h0003);
         load(2, wd1, 16'h20c5, 16'h0000);
         run_q;
         exp_exec(wd1);
         wait_idle;
         set_reg(5'h03, 16'h0003);
         load(2, 16'h20c2, wd1, 16'h0000);
         run_q;
         exp_exec(wd1);
         wait_idle;
      end
   endtask
   task t_stop_jump;
      begin
         load(3, wd1, 16'h1000, wd2);
         run_q;
         exp_exec(wd1);
         wait_idle;
         run_q;
         exp_exec(wd1);
         wait_idle;
         load(1, wd4, 16'h0000, 16'h0000);
         cmd(`PQS_H_STORE, 4'h2, 16'h0000, `PQS_R_ACK);
         load(2, 16'h3080, wd2, 16'h0000);
         run_q;
         exp_exec(wd4);
         wait_idle;
         cond <= 8'h01;
         load(3, 16'h4003, wd1, wd2);
         run_q;
         exp_exec(wd2);
         wait_idle;
         cond <= 8'h00;
         run_q;
         exp_exec(wd1);
         exp_exec(wd2);
         wait_idle;
      end
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_fill_store;
      t_refusals;
      t_loop;
      t_stop_jump;
      complete_run;
   end
endmodule // tb_pqs_sequencer
bind pqs_sequencer pqs_sequencer_assertions u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
   .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i),
   .cmd_arg_i(cmd_arg_i), .rep_valid_o(rep_valid_o), .rep_ready_i(rep_ready_i),
   .rep_kind_o(rep_kind_o), .rep_value_o(rep_value_o), .exec_valid_o(exec_valid_o),
   .exec_ready_i(exec_ready_i), .exec_word_o(exec_word_o), .running_o(running_o),
   .filling_o(filling_o));
